// ---- frps_pkg.sv ----
package frps_pkg;
  // ----------------------------------------
  // Timing figures, burst limit, status bit positions and counter width
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_ACTIVE_MAX_NS = 20000;
  localparam int RESET_IDLE_MAX_NS = 500;
  localparam int RESET_TO_STANDBY_US = 20;
  localparam int RESET_RELEASE_TO_READ_NS = 50;
  localparam int STATUS_VALID_US = 4;
  localparam int ACCESS_NS = 90;
  localparam int READ_PULSE_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RESET_RELEASE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_CYC = (RESET_ACTIVE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_VALID_CYC = (STATUS_VALID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_BURST = 16;
  localparam int BUSY_BIT = 6;
  localparam int SUSP_BIT = 2;
  localparam int CNT_W = 16;
endpackage

// ---- frps_pulse.sv ----
`timescale 1ns/1ns
module frps_pulse #(
  parameter int W = 16
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic ce, // Clock enable
  input wire logic load, // Start count
  input wire logic [W-1:0] value, // Cycles to count
  output logic done // High when idle
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = value;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end
  assign done = (cnt == '0);
endmodule

// ---- frps_host.sv ----
`timescale 1ns/1ns
// Functional notes
// - Host waits 50 ns after reset release before reading.
// - Buffered program takes 1 to 16 words; host never loads more.
// - Status valid 4 us after program command; host waits.
// - Suspend before status-valid delay means full wait again on resume.
// - Toggle bits advance per read; host pulses output enable.
// - During erase host polls inside the erased sector.
module frps_host #(
  parameter int AW = 22,
  parameter int DW = 16,
  parameter int RESET_LOW_CYCLES = frps_pkg::RESET_LOW_CYC
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic reset_req, // Pulse flash reset pin
  input wire logic poll_req, // Start status polling
  input wire logic [AW-1:0] poll_addr, // Sector address to poll
  input wire logic [4:0] burst_len, // Words to be programmed
  input wire logic suspended, // Program suspended
  output logic busy, // Sequence running
  output logic op_done, // Pulse: operation finished
  output logic burst_err, // Pulse: burst over limit
  output logic flash_reset_n, // Flash reset pin
  output logic flash_ce_n, // Flash chip enable
  output logic flash_oe_n, // Flash output enable
  output logic flash_we_n, // Flash write enable
  output logic [AW-1:0] flash_addr, // Flash address
  input wire logic [DW-1:0] flash_dq // Flash data in
);
  // ----------------------------------------
  // Data input synchroniser
  // ----------------------------------------
  logic [DW-1:0] dq_s1, dq_s2, dq_s3;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end else if (ce) begin
      dq_s1 <= flash_dq;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RST_LOW, ST_RECOVER, ST_WAIT_VALID, ST_READ, ST_GAP, ST_DONE
  } frps_state_type;
  frps_state_type state, next_state;
  logic [AW-1:0] addr, next_addr;
  logic have_prev, next_have_prev;
  logic prev_busy, next_prev_busy;
  logic valid_seen, next_valid_seen;
  logic tload;
  logic [frps_pkg::CNT_W-1:0] tval;
  logic tdone;
  logic read_stable;
  frps_pulse #(.W(frps_pkg::CNT_W)) u_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .load(tload),
    .value(tval),
    .done(tdone)
  );
  assign read_stable = (dq_s2 == dq_s3);
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_have_prev = have_prev;
    next_prev_busy = prev_busy;
    next_valid_seen = valid_seen;
    tload = 1'b0;
    tval = '0;
    case (state)
      ST_IDLE: begin
        if (reset_req) begin
          tload = 1'b1;
          tval = frps_pkg::CNT_W'(RESET_LOW_CYCLES);
          next_state = ST_RST_LOW;
        end else if (poll_req && burst_len <= 5'(frps_pkg::MAX_BURST)) begin
          next_addr = poll_addr;
          next_have_prev = 1'b0;
          if (!valid_seen) begin
            tload = 1'b1;
            tval = frps_pkg::CNT_W'(frps_pkg::STATUS_VALID_CYC);
          end
          next_state = ST_WAIT_VALID;
        end
      end
      ST_RST_LOW: begin
        if (tdone) begin
          tload = 1'b1;
          tval = frps_pkg::CNT_W'(frps_pkg::RECOVER_CYC);
          next_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (tdone) begin
          next_valid_seen = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_WAIT_VALID: begin
        if (suspended) begin
          // Restart the full status wait on resume
          tload = 1'b1;
          tval = frps_pkg::CNT_W'(frps_pkg::STATUS_VALID_CYC);
        end else if (tdone) begin
          next_valid_seen = 1'b1;
          tload = 1'b1;
          tval = frps_pkg::CNT_W'(frps_pkg::READ_PULSE_CYC + 2);
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        // Sample only once the last two sync stages agree
        if (tdone && read_stable) begin
          next_state = ST_GAP;
          if (have_prev && prev_busy == dq_s3[frps_pkg::BUSY_BIT]) begin
            next_state = ST_DONE;
          end
          next_prev_busy = dq_s3[frps_pkg::BUSY_BIT];
          next_have_prev = 1'b1;
        end
      end
      ST_GAP: begin
        tload = 1'b1;
        tval = frps_pkg::CNT_W'(frps_pkg::READ_PULSE_CYC + 2);
        next_state = ST_READ;
      end
      ST_DONE: begin
        next_valid_seen = 1'b0;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (suspended && state == ST_WAIT_VALID) begin
      next_valid_seen = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      addr <= '0;
      have_prev <= 1'b0;
      prev_busy <= 1'b0;
      valid_seen <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      addr <= next_addr;
      have_prev <= next_have_prev;
      prev_busy <= next_prev_busy;
      valid_seen <= next_valid_seen;
    end
  end
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign flash_reset_n = (state != ST_RST_LOW);
  assign flash_ce_n = (state != ST_READ);
  assign flash_oe_n = (state != ST_READ);
  assign flash_we_n = 1'b1;
  assign flash_addr = addr;
  assign busy = (state != ST_IDLE);
  assign op_done = (state == ST_DONE);
  assign burst_err = (state == ST_IDLE) && poll_req && !reset_req
    && (burst_len > 5'(frps_pkg::MAX_BURST));
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Counts cycles of the reset pulse
  logic [frps_pkg::CNT_W-1:0] low_cnt, next_low_cnt;
  always_comb begin
    next_low_cnt = '0;
    if (!flash_reset_n) begin
      next_low_cnt = low_cnt + frps_pkg::CNT_W'(1);
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= '0;
    end else if (ce) begin
      low_cnt <= next_low_cnt;
    end
  end
  sequence reset_release_s;
    $rose(flash_reset_n);
  endsequence
  reset_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reset_release_s |-> low_cnt == frps_pkg::CNT_W'(RESET_LOW_CYCLES + 1))
    else $error("Reset pulse length wrong");
  read_gap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reset_release_s |-> flash_oe_n [*2]) else $error("Read too soon after reset");
  burst_refuse_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    burst_err && ce |=> !busy) else $error("Long burst accepted");
  done_after_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(op_done) |-> !$past(flash_oe_n)) else $error("Done without status read");
  no_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    flash_we_n) else $error("Write strobe driven");
  addr_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !flash_oe_n && ce |=> $stable(flash_addr)) else $error("Address moved in poll");
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    op_done && ce |=> !op_done) else $error("Done not a pulse");
endmodule

// ---- frps_flash_model.sv ----
`timescale 1ns/1ns
module frps_flash_model #(
  parameter int DW = 16
) (
  input wire logic flash_reset_n, // Reset pin
  input wire logic flash_ce_n, // Chip enable
  input wire logic flash_oe_n, // Output enable
  input wire logic arm, // Start embedded op
  input wire logic [3:0] reads, // Busy status reads
  output logic [DW-1:0] flash_dq // Data out
);
  logic rd;
  logic tog = 1'b0;
  logic [DW-1:0] val;
  int left = 0;
  assign rd = !(flash_ce_n || flash_oe_n);
  // Status at any address; no suspended sector so bit 2 stays still
  // Sleep on a resting address leaves status reads intact
  assign val = DW'(tog) << frps_pkg::BUSY_BIT;
  // Deselected bus shows the inverse of the last word
  assign flash_dq = rd ? val : ~val;
  always @(arm or negedge flash_reset_n) begin
    if (!flash_reset_n) left = 0;
    else left = reads;
  end
  always @(posedge rd) begin
    if (left > 0) begin
      tog = ~tog;
      left--;
    end
  end
endmodule

// ---- frps_host_test.sv ----
`timescale 1ns/1ns
module frps_host_test;
  localparam int RLC = 4;
  logic ref_clk = 0, arst_n = 0, reset_req = 0, poll_req = 0, suspended = 0, arm = 0;
  logic ce = 1, we_n;
  logic [21:0] poll_addr = '0;
  logic [21:0] fa;
  logic [4:0] burst_len = 5'h01;
  logic [3:0] reads = 4'h0;
  logic busy, op_done, burst_err, rst_n, ce_n, oe_n;
  logic [15:0] dq;
  logic [1:0] exp_q[$];
  int fail_count = 0, total_checks = 0, seed = 954, n, i;
  always #20 ref_clk = ~ref_clk;
  frps_host #(.RESET_LOW_CYCLES(RLC)) i_frps_host (.ref_clk(ref_clk), .arst_n(arst_n),
    .ce(ce), .reset_req(reset_req), .poll_req(poll_req), .poll_addr(poll_addr),
    .burst_len(burst_len), .suspended(suspended), .busy(busy), .op_done(op_done),
    .burst_err(burst_err), .flash_reset_n(rst_n), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(fa), .flash_dq(dq));
  frps_flash_model i_frps_flash_model (.flash_reset_n(rst_n), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .arm(arm), .reads(reads), .flash_dq(dq));
  task end_of_test;
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cmp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %b expected %b", $time, got, exp);
    end
  endtask
  task cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task bounded(input logic hit);
    n++;
    if (n > 30000 && !hit) begin
      fail_count++;
      $display("MISMATCH %0t wait timed out", $time);
      end_of_test();
    end
  endtask
  task wait_idle;
    n = 0;
    while (busy !== 1'b0) begin
      @(negedge ref_clk);
      bounded(1'b0);
    end
  endtask
  task poll(input logic [4:0] len, input int susp);
    exp_q.push_back({len > 5'h10, len <= 5'h10});
    @(negedge ref_clk);
    reads = 4'($random(seed));
    arm = ~arm;
    burst_len = len;
    poll_addr = 22'($random(seed));
    poll_req = 1;
    @(negedge ref_clk);
    poll_req = 0;
    if (len > 5'h10) return;
    n = 0;
    while (oe_n !== 1'b0) begin
      suspended = susp > 0 && n >= 40 && n < 40 + susp;
      ce = suspended || ($random(seed) & 7) != 0;
      @(negedge ref_clk);
      bounded(1'b0);
    end
    ce = 1;
    cmp(n >= (susp > 0 ? 40 + susp : 0) + frps_pkg::STATUS_VALID_CYC - 1, 1);
    cmp_cnt(32'(fa), 32'(poll_addr));
    cmp(we_n, 1);
    wait_idle();
  endtask
  // Each result pulse takes the oldest note
  always @(posedge ref_clk) begin
    if (op_done === 1'b1 || burst_err === 1'b1) begin
      if (exp_q.size() == 0) cmp({burst_err, op_done}, 2'b00);
      else cmp({burst_err, op_done}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    arst_n = 1;
    reads = 4'h9;
    arm = 1;
    @(negedge ref_clk);
    reset_req = 1;
    @(negedge ref_clk);
    reset_req = 0;
    n = 0;
    while (rst_n !== 1'b0) begin
      @(negedge ref_clk);
      bounded(1'b0);
    end
    i = n;
    n = 0;
    while (rst_n !== 1'b1) begin
      @(negedge ref_clk);
      bounded(1'b0);
    end
    cmp_cnt(n, RLC + 1);
    n = 0;
    while (busy !== 1'b0) begin
      cmp(oe_n, 1);
      @(negedge ref_clk);
      bounded(1'b0);
    end
    cmp(n >= frps_pkg::RECOVER_CYC, 1);
    poll(5'h10, 0);
    poll(5'h11, 0);
    poll(5'h01, 25);
    for (i = 0; i < 4; i++) poll(5'($random(seed)), i * 7);
    repeat (3) @(negedge ref_clk);
    cmp_cnt(exp_q.size(), 0);
    end_of_test();
  end
endmodule
